// *** shared/qbp_pkg.sv ***
// Constants shared by the quasi-bidirectional port block and its pin cells.
// Assumes a single 250 MHz system clock and an asynchronous active-high reset.
`default_nettype none
package qbp_pkg;
   localparam int PORT_W = 8;
   localparam int CLK_PERIOD_NS = 4;
   // The momentary strong pull-up must last at least this long.
   localparam int STRONG_PU_NS = 10;
   localparam int STRONG_PU_CYC = (STRONG_PU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PU_CNT_W = 3;
   localparam logic [7:0] LATCH_RST = 8'hFF;
   localparam logic [7:0] FIRST_LATCH_EA_LOW = 8'h0E;
   localparam logic [7:0] FIRST_FUNC_RST = 8'h00;
   localparam logic [7:0] FIRST_FUNC_EA_LOW = 8'hFF;
   localparam logic [7:0] SECOND_ALT_MASK = 8'hF7;
   localparam logic [7:0] ALT_IDLE_HIGH = 8'hFF;

   typedef enum logic [3:0] {
      STRAP_SYNC1 = 4'b0001,
      STRAP_SYNC2 = 4'b0010,
      STRAP_LOAD = 4'b0100,
      STRAP_DONE = 4'b1000
   } qbp_strap_type;
endpackage : qbp_pkg
`default_nettype wire

// *** src/qbp_pin_mux.sv ***
// Pin logic for three quasi-bidirectional 8-bit ports with alternate functions.
// Assumes peripherals on CLK_SYS; pins and the external-access strap are asynchronous.
`default_nettype none
module qbp_pin_mux (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic EXTERNAL_ACCESS_SELECT,
   input wire logic [2:0] PORT_WR_STB,
   input wire logic [qbp_pkg::PORT_W-1:0] PORT_WR_DATA,
   input wire logic FUNC_CTRL_WR_STB,
   input wire logic [qbp_pkg::PORT_W-1:0] FUNC_CTRL_WR_DATA,
   input wire logic [qbp_pkg::PORT_W-1:0] SECOND_ALT_EN,
   input wire logic [qbp_pkg::PORT_W-1:0] THIRD_ALT_EN,
   input wire logic [7:0] PROG_CHIP_EN_N,
   input wire logic [5:0] UPPER_ADDR,
   input wire logic CAN_TRANSMIT,
   input wire logic [3:0] PERIPH_SELECT_N,
   input wire logic THIRD_SERIAL_TRANSMIT,
   input wire logic [qbp_pkg::PORT_W-1:0] FIRST_PIN_IN,
   input wire logic [qbp_pkg::PORT_W-1:0] SECOND_PIN_IN,
   input wire logic [qbp_pkg::PORT_W-1:0] THIRD_PIN_IN,
   output logic [qbp_pkg::PORT_W-1:0] FIRST_PIN_OUT,
   output logic [qbp_pkg::PORT_W-1:0] FIRST_PIN_OE_N,
   output logic [qbp_pkg::PORT_W-1:0] FIRST_WEAK_PU,
   output logic [qbp_pkg::PORT_W-1:0] FIRST_RD_DATA,
   output logic [qbp_pkg::PORT_W-1:0] SECOND_PIN_OUT,
   output logic [qbp_pkg::PORT_W-1:0] SECOND_PIN_OE_N,
   output logic [qbp_pkg::PORT_W-1:0] SECOND_WEAK_PU,
   output logic [qbp_pkg::PORT_W-1:0] SECOND_RD_DATA,
   output logic [qbp_pkg::PORT_W-1:0] THIRD_PIN_OUT,
   output logic [qbp_pkg::PORT_W-1:0] THIRD_PIN_OE_N,
   output logic [qbp_pkg::PORT_W-1:0] THIRD_WEAK_PU,
   output logic [qbp_pkg::PORT_W-1:0] THIRD_RD_DATA,
   output logic [qbp_pkg::PORT_W-1:0] FIRST_FUNC_CTRL,
   output logic CAN_RECEIVE,
   output logic THIRD_TIMER_EXT_INPUT,
   output logic THIRD_SERIAL_RECEIVE,
   output logic STRAP_DONE_FLAG
);
   import qbp_pkg::*;

   qbp_strap_type strap_reg, strap_next;
   logic acc_sync1_reg, acc_sync2_reg;
   logic [PORT_W-1:0] func_reg, func_next;
   logic strap_low_load;
   logic [PORT_W-1:0] first_alt, second_alt, third_alt;
   logic [PORT_W-1:0] second_en;

   // The strap is caught after release, once the two-flop synchroniser has settled.
   always_comb begin
      case (strap_reg)
         STRAP_SYNC1: strap_next = STRAP_SYNC2;
         STRAP_SYNC2: strap_next = STRAP_LOAD;
         STRAP_LOAD: strap_next = STRAP_DONE;
         STRAP_DONE: strap_next = STRAP_DONE;
         default: strap_next = STRAP_SYNC1;
      endcase
      strap_low_load = (strap_reg == STRAP_LOAD) && !acc_sync2_reg;
      func_next = func_reg;
      if (strap_low_load) begin
         func_next = FIRST_FUNC_EA_LOW;
      end else if (FUNC_CTRL_WR_STB) begin
         func_next = FUNC_CTRL_WR_DATA;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         strap_reg <= STRAP_SYNC1;
         acc_sync1_reg <= 1'b1;
         acc_sync2_reg <= 1'b1;
         func_reg <= FIRST_FUNC_RST;
         FIRST_FUNC_CTRL <= FIRST_FUNC_RST;
         STRAP_DONE_FLAG <= 1'b0;
      end else begin
         strap_reg <= strap_next;
         acc_sync1_reg <= EXTERNAL_ACCESS_SELECT;
         acc_sync2_reg <= acc_sync1_reg;
         func_reg <= func_next;
         FIRST_FUNC_CTRL <= func_next;
         STRAP_DONE_FLAG <= (strap_next == STRAP_DONE);
      end
   end

   // Input-only alternates present a high level so the pin rests on the weak pull-up.
   assign first_alt = {UPPER_ADDR[3:0], PROG_CHIP_EN_N[3:0]};
   assign second_alt = {PERIPH_SELECT_N, 3'b111, CAN_TRANSMIT};
   assign third_alt = {THIRD_SERIAL_TRANSMIT, 1'b1, UPPER_ADDR[5:4],
                       PROG_CHIP_EN_N[7:4]};
   assign second_en = SECOND_ALT_EN & SECOND_ALT_MASK;

   qbp_port_cell #(.W(PORT_W)) u_first (
      .clk(CLK_SYS),
      .rst(RST),
      .wr_stb(PORT_WR_STB[0]),
      .wr_data(PORT_WR_DATA),
      .load_stb(strap_low_load),
      .load_data(FIRST_LATCH_EA_LOW),
      .alt_en(func_reg),
      .alt_out(first_alt),
      .pin_in(FIRST_PIN_IN),
      .pin_out(FIRST_PIN_OUT),
      .pin_oe_n(FIRST_PIN_OE_N),
      .weak_pu(FIRST_WEAK_PU),
      .rd_data(FIRST_RD_DATA)
   );

   qbp_port_cell #(.W(PORT_W)) u_second (
      .clk(CLK_SYS),
      .rst(RST),
      .wr_stb(PORT_WR_STB[1]),
      .wr_data(PORT_WR_DATA),
      .load_stb(1'b0),
      .load_data(ALT_IDLE_HIGH),
      .alt_en(second_en),
      .alt_out(second_alt),
      .pin_in(SECOND_PIN_IN),
      .pin_out(SECOND_PIN_OUT),
      .pin_oe_n(SECOND_PIN_OE_N),
      .weak_pu(SECOND_WEAK_PU),
      .rd_data(SECOND_RD_DATA)
   );

   qbp_port_cell #(.W(PORT_W)) u_third (
      .clk(CLK_SYS),
      .rst(RST),
      .wr_stb(PORT_WR_STB[2]),
      .wr_data(PORT_WR_DATA),
      .load_stb(1'b0),
      .load_data(ALT_IDLE_HIGH),
      .alt_en(THIRD_ALT_EN),
      .alt_out(third_alt),
      .pin_in(THIRD_PIN_IN),
      .pin_out(THIRD_PIN_OUT),
      .pin_oe_n(THIRD_PIN_OE_N),
      .weak_pu(THIRD_WEAK_PU),
      .rd_data(THIRD_RD_DATA)
   );

   // Receive-side alternates read the synchronised pin level.
   assign CAN_RECEIVE = SECOND_RD_DATA[1];
   assign THIRD_TIMER_EXT_INPUT = SECOND_RD_DATA[2];
   assign THIRD_SERIAL_RECEIVE = THIRD_RD_DATA[6];

   a_strap_low_load: assert property (@(posedge CLK_SYS) disable iff (RST)
      (strap_reg == STRAP_LOAD && !acc_sync2_reg) |=> ##1
      (FIRST_PIN_OUT[3:1] == 3'b111 && FIRST_FUNC_CTRL == FIRST_FUNC_EA_LOW))
      else $error("strap low did not raise chip enables 3..1");
   a_strap_low_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
      (strap_reg == STRAP_LOAD && !acc_sync2_reg && !FUNC_CTRL_WR_STB) |=>
      (func_reg == FIRST_FUNC_EA_LOW))
      else $error("strap low did not assign address and chip-enable roles");
   a_strap_high_keep: assert property (@(posedge CLK_SYS) disable iff (RST)
      (strap_reg == STRAP_LOAD && acc_sync2_reg && !FUNC_CTRL_WR_STB) |=>
      (func_reg == $past(func_reg)))
      else $error("strap high changed the function control");
   a_strap_done_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
      strap_reg == STRAP_LOAD |=> STRAP_DONE_FLAG)
      else $error("strap handling not flagged as done");
   a_func_write: assert property (@(posedge CLK_SYS) disable iff (RST)
      (FUNC_CTRL_WR_STB && strap_reg != STRAP_LOAD) |=> func_reg == $past(FUNC_CTRL_WR_DATA))
      else $error("function-control write lost");
   a_first_alt_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      func_reg[0] && func_reg[7] |=>
      (FIRST_PIN_OUT[0] == $past(PROG_CHIP_EN_N[0]) && FIRST_PIN_OUT[7] == $past(UPPER_ADDR[3])))
      else $error("first port alternate not driven");
   a_first_alt_mid: assert property (@(posedge CLK_SYS) disable iff (RST)
      func_reg[3] && func_reg[4] |=>
      (FIRST_PIN_OUT[3] == $past(PROG_CHIP_EN_N[3]) && FIRST_PIN_OUT[4] == $past(UPPER_ADDR[0])))
      else $error("first port chip enable 3 or address 16 not driven");
   a_can_tx_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      SECOND_ALT_EN[0] |=> SECOND_PIN_OUT[0] == $past(CAN_TRANSMIT))
      else $error("CAN transmit not on second port bit 0");
   // Bit 3 has no alternate, so a written zero must reach the pin even when enabled.
   a_no_alt_bit3: assert property (@(posedge CLK_SYS) disable iff (RST)
      (PORT_WR_STB[1] && !PORT_WR_DATA[3]) ##1 SECOND_ALT_EN[3] |=> !SECOND_PIN_OUT[3])
      else $error("second port bit 3 took an alternate function");
   a_periph_sel_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      SECOND_ALT_EN[4] |=> SECOND_PIN_OUT[4] == $past(PERIPH_SELECT_N[0]))
      else $error("peripheral select 0 not on second port bit 4");
   a_periph_sel_top: assert property (@(posedge CLK_SYS) disable iff (RST)
      SECOND_ALT_EN[7] |=> SECOND_PIN_OUT[7] == $past(PERIPH_SELECT_N[3]))
      else $error("peripheral select 3 not on second port bit 7");
   a_third_ce_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      THIRD_ALT_EN[0] |=> THIRD_PIN_OUT[0] == $past(PROG_CHIP_EN_N[4]))
      else $error("chip enable 4 not on third port bit 0");
   a_third_ce_top: assert property (@(posedge CLK_SYS) disable iff (RST)
      THIRD_ALT_EN[3] && THIRD_ALT_EN[5] |=>
      (THIRD_PIN_OUT[3] == $past(PROG_CHIP_EN_N[7]) && THIRD_PIN_OUT[5] == $past(UPPER_ADDR[5])))
      else $error("chip enable 7 or address 21 missing on third port");
   a_third_tx_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      THIRD_ALT_EN[7] && THIRD_ALT_EN[4] |=>
      (THIRD_PIN_OUT[7] == $past(THIRD_SERIAL_TRANSMIT)
      && THIRD_PIN_OUT[4] == $past(UPPER_ADDR[4])))
      else $error("third port serial or address alternate missing");
   a_rx_latency: assert property (@(posedge CLK_SYS) disable iff (RST)
      ##3 1'b1 |-> (CAN_RECEIVE == $past(SECOND_PIN_IN[1], 3)
      && THIRD_TIMER_EXT_INPUT == $past(SECOND_PIN_IN[2], 3)
      && THIRD_SERIAL_RECEIVE == $past(THIRD_PIN_IN[6], 3)))
      else $error("receive alternate does not follow its pin");
   a_latch_reset_high: assert property (@(posedge CLK_SYS)
      $fell(RST) |-> (SECOND_PIN_OUT == LATCH_RST && THIRD_PIN_OE_N == LATCH_RST))
      else $error("ports not weakly high after reset");
   c_strap_low: cover property (@(posedge CLK_SYS) disable iff (RST)
      strap_reg == STRAP_LOAD && !acc_sync2_reg);
   c_alt_can: cover property (@(posedge CLK_SYS) disable iff (RST)
      SECOND_ALT_EN[0] && !CAN_TRANSMIT);
   c_func_write: cover property (@(posedge CLK_SYS) disable iff (RST) FUNC_CTRL_WR_STB);
endmodule : qbp_pin_mux
`default_nettype wire

// *** src/qbp_port_cell.sv ***
// One quasi-bidirectional port: output latch, strong low, momentary strong high,
// weak sustaining pull-up and a synchronised read-back of the pin levels.
// Assumes the pin resolver outside applies the weak pull-up when weak_pu is high.
`default_nettype none
module qbp_port_cell #(
   parameter int W = qbp_pkg::PORT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_stb,
   input wire logic [W-1:0] wr_data,
   input wire logic load_stb,
   input wire logic [W-1:0] load_data,
   input wire logic [W-1:0] alt_en,
   input wire logic [W-1:0] alt_out,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe_n,
   output logic [W-1:0] weak_pu,
   output logic [W-1:0] rd_data
);
   import qbp_pkg::*;

   logic [W-1:0] latch_reg, latch_next;
   logic [W-1:0] eff_reg, eff_next;
   logic [PU_CNT_W-1:0] pu_cnt_reg [W];
   logic [PU_CNT_W-1:0] pu_cnt_next [W];
   logic [W-1:0] out_next, oe_n_next;
   logic [W-1:0] sync1_reg, sync2_reg;

   always_comb begin
      latch_next = latch_reg;
      if (load_stb) begin
         latch_next = load_data;
      end else if (wr_stb) begin
         latch_next = wr_data;
      end
      // An enabled alternate function owns the pin instead of the latch.
      eff_next = (alt_en & alt_out) | (~alt_en & latch_reg);
      for (int i = 0; i < W; i++) begin
         pu_cnt_next[i] = '0;
         if (eff_next[i] && !eff_reg[i]) begin
            pu_cnt_next[i] = PU_CNT_W'(STRONG_PU_CYC);
         end else if (eff_next[i] && pu_cnt_reg[i] != '0) begin
            pu_cnt_next[i] = pu_cnt_reg[i] - PU_CNT_W'(1);
         end
         out_next[i] = eff_next[i];
         // Strong drive while low, or during the transition pulse; weak otherwise.
         oe_n_next[i] = eff_next[i] && (pu_cnt_next[i] == '0);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_reg <= LATCH_RST;
         eff_reg <= LATCH_RST;
         for (int i = 0; i < W; i++) begin
            pu_cnt_reg[i] <= '0;
         end
         pin_out <= LATCH_RST;
         pin_oe_n <= LATCH_RST;
         weak_pu <= LATCH_RST;
         sync1_reg <= '0;
         sync2_reg <= '0;
         rd_data <= '0;
      end else begin
         latch_reg <= latch_next;
         eff_reg <= eff_next;
         pu_cnt_reg <= pu_cnt_next;
         pin_out <= out_next;
         pin_oe_n <= oe_n_next;
         weak_pu <= eff_next;
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         rd_data <= sync2_reg;
      end
   end

   // The pin follows the latch one edge after the write, so the enable is judged there.
   a_strong_low_drive: assert property (@(posedge clk) disable iff (rst)
      (wr_stb && !load_stb && !wr_data[0]) ##1 !alt_en[0]
      |=> (!pin_oe_n[0] && !pin_out[0]))
      else $error("pin held low without strong pulldown");
   a_pullup_pulse_len: assert property (@(posedge clk) disable iff (rst)
      $rose(pin_out[0]) |-> (!pin_oe_n[0])[*3] ##1 (pin_oe_n[0] || !pin_out[0]))
      else $error("momentary pull-up has the wrong length");
   a_pin_readback: assert property (@(posedge clk) disable iff (rst)
      ##3 1'b1 |-> rd_data == $past(pin_in, 3))
      else $error("read-back does not follow the pin level");
   c_pullup_pulse: cover property (@(posedge clk) disable iff (rst)
      $rose(pin_out[0]) ##3 pin_oe_n[0]);
   c_input_override: cover property (@(posedge clk) disable iff (rst)
      pin_oe_n[0] && weak_pu[0] ##3 !rd_data[0]);
endmodule : qbp_port_cell
`default_nettype wire

// *** tb/qbp_pin_model.sv ***
// Board side of one 8-bit quasi-bidirectional port: outside drivers and pin resolution.
// Assumes the port's outputs are registered on clk and a set weak_pu bit means pull-up.
`default_nettype none
module qbp_pin_model (
   input wire logic clk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] weak_pu,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_reg = 8'h00;
   always_ff @(posedge clk) begin
      last_reg <= pin_lvl;
   end
   // An undriven pin with no pull-up wanders, so nothing may rely on its last value.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n[i]) begin
            pin_lvl[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_lvl[i] = ext_val[i];
         end else if (weak_pu[i]) begin
            pin_lvl[i] = 1'b1;
         end else begin
            pin_lvl[i] = ~last_reg[i];
         end
      end
   end
endmodule : qbp_pin_model
`default_nettype wire

// *** tb/tb_qbp_pin_mux.sv ***
// Self-checking bench for the three-port quasi-bidirectional pin block.
// Assumes one 250 MHz clock; board pins are resolved by qbp_pin_model.
`default_nettype none
module tb_qbp_pin_mux;
   timeunit 1ns;
   timeprecision 1ps;
   import qbp_pkg::*;
   logic CLK_SYS = 1'b0, RST = 1'b1, EXT_ACC = 1'b1, FC_STB = 1'b0, CAN_TX = 1'b1, SER_TX = 1'b1;
   logic [2:0] WR_STB = 3'b000;
   logic [7:0] WR_DATA = 8'h00, FC_DATA = 8'h00, ALT2 = 8'h00, ALT3 = 8'h00, PCE_N = 8'hFF;
   logic [5:0] UADDR = 6'h00;
   logic [3:0] PSEL_N = 4'hF;
   logic [7:0] EN [3] = '{default: 8'h00};
   logic [7:0] VAL [3] = '{default: 8'h00};
   logic [7:0] PO [3], OE [3], PU [3], RD [3], LVL [3];
   logic [7:0] FCTRL;
   logic CAN_RX, TMR, SER_RX, DONE;
   int error_cnt = 0;
   int samples_checked = 0;
   initial begin
      forever #2 CLK_SYS = ~CLK_SYS;
   end
   qbp_pin_mux dut (.CLK_SYS(CLK_SYS), .RST(RST), .EXTERNAL_ACCESS_SELECT(EXT_ACC),
      .PORT_WR_STB(WR_STB), .PORT_WR_DATA(WR_DATA), .FUNC_CTRL_WR_STB(FC_STB),
      .FUNC_CTRL_WR_DATA(FC_DATA), .SECOND_ALT_EN(ALT2), .THIRD_ALT_EN(ALT3),
      .PROG_CHIP_EN_N(PCE_N), .UPPER_ADDR(UADDR), .CAN_TRANSMIT(CAN_TX),
      .PERIPH_SELECT_N(PSEL_N), .THIRD_SERIAL_TRANSMIT(SER_TX), .FIRST_PIN_IN(LVL[0]),
      .SECOND_PIN_IN(LVL[1]), .THIRD_PIN_IN(LVL[2]), .FIRST_PIN_OUT(PO[0]),
      .FIRST_PIN_OE_N(OE[0]), .FIRST_WEAK_PU(PU[0]), .FIRST_RD_DATA(RD[0]),
      .SECOND_PIN_OUT(PO[1]), .SECOND_PIN_OE_N(OE[1]), .SECOND_WEAK_PU(PU[1]),
      .SECOND_RD_DATA(RD[1]), .THIRD_PIN_OUT(PO[2]), .THIRD_PIN_OE_N(OE[2]),
      .THIRD_WEAK_PU(PU[2]), .THIRD_RD_DATA(RD[2]), .FIRST_FUNC_CTRL(FCTRL),
      .CAN_RECEIVE(CAN_RX), .THIRD_TIMER_EXT_INPUT(TMR), .THIRD_SERIAL_RECEIVE(SER_RX),
      .STRAP_DONE_FLAG(DONE));
   for (genvar p = 0; p < 3; p++) begin : g_board
      qbp_pin_model board (.clk(CLK_SYS), .pin_out(PO[p]), .pin_oe_n(OE[p]),
         .weak_pu(PU[p]), .ext_en(EN[p]), .ext_val(VAL[p]), .pin_lvl(LVL[p]));
   end
   task automatic tick(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask : tick
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic port_wr(input int p, input logic [7:0] d);
      tick(1);
      WR_STB[p] = 1'b1;
      WR_DATA = d;
      tick(1);
      WR_STB = 3'b000;
   endtask : port_wr
   task automatic func_wr(input logic [7:0] d);
      tick(1);
      FC_STB = 1'b1;
      FC_DATA = d;
      tick(1);
      FC_STB = 1'b0;
   endtask : func_wr
   task automatic do_reset(input logic acc_lvl);
      int n;
      tick(1);
      RST = 1'b1;
      EXT_ACC = acc_lvl;
      tick(16);
      chk("second out in reset", 8'hFF, PO[1] & PU[1] & OE[1]);
      chk("third out in reset", 8'hFF, PO[2] & PU[2] & OE[2]);
      RST = 1'b0;
      n = 0;
      while (DONE !== 1'b1 && n < 10) begin
         n++;
         tick(1);
      end
      tick(3);
   endtask : do_reset
   task automatic test_strap;
      PCE_N = 8'hFE;
      UADDR = 6'h00;
      do_reset(1'b0);
      chk("func ctrl, strap low", 8'hFF, FCTRL);
      chk("first pins, strap low", 8'h0E, PO[0]);
      PCE_N = 8'hF5;
      UADDR = 6'h0A;
      tick(3);
      chk("first alternates", 8'hA5, PO[0]);
      do_reset(1'b1);
      chk("func ctrl, strap high", 8'h00, FCTRL);
      chk("first pins, strap high", 8'hFF, PO[0] & PU[0]);
      chk("third rests weak", 8'hFF, OE[2]);
      $display("test strap done");
   endtask : test_strap
   task automatic test_func;
      func_wr(8'h0F);
      port_wr(0, 8'h00);
      tick(3);
      chk("func ctrl", 8'h0F, FCTRL);
      chk("first mixed pins", 8'h05, PO[0]);
      chk("first drive", 8'h05, OE[0]);
      tick(2);
      chk("first read-back", 8'h05, RD[0]);
      func_wr(8'h00);
      tick(3);
      chk("first latch pins", 8'h00, PO[0]);
      $display("test func done");
   endtask : test_func
   task automatic test_drive;
      int n;
      port_wr(2, 8'h00);
      tick(3);
      chk("strong low", 8'h00, PO[2] | OE[2]);
      tick(8);
      chk("strong low held", 8'h00, PO[2] | OE[2]);
      port_wr(2, 8'hFF);
      n = 0;
      while (PO[2] !== 8'hFF && n < 6) begin
         n++;
         tick(1);
      end
      n = 0;
      while (OE[2] === 8'h00 && n < 8) begin
         n++;
         tick(1);
      end
      chk("strong high cycles", 8'(STRONG_PU_CYC), 8'(n));
      chk("weak after pulse", 8'hFF, OE[2] & PU[2]);
      EN[2] = 8'h0F;
      tick(5);
      chk("read override", 8'hF0, RD[2]);
      EN[2] = 8'h00;
      tick(5);
      chk("read released", 8'hFF, RD[2]);
      $display("test drive done");
   endtask : test_drive
   task automatic test_alt;
      port_wr(1, 8'h00);
      ALT2 = 8'hFF;
      CAN_TX = 1'b0;
      PSEL_N = 4'h5;
      EN[1] = 8'h02;
      ALT3 = 8'hFF;
      PCE_N = 8'hAF;
      UADDR = 6'h10;
      SER_TX = 1'b0;
      EN[2] = 8'h40;
      tick(12);
      chk("second alternates", 8'h56, PO[1]);
      chk("can receive", 8'h00, {7'h00, CAN_RX});
      chk("timer input", 8'h01, {7'h00, TMR});
      chk("second read-back", 8'h54, RD[1]);
      chk("third alternates", 8'h5A, PO[2]);
      chk("serial receive", 8'h00, {7'h00, SER_RX});
      $display("test alternates done");
   endtask : test_alt
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      test_strap();
      test_func();
      test_drive();
      test_alt();
      complete_run();
   end
   // The tests need well under a thousand cycles; this leaves ample margin.
   initial begin
      #20000;
      error_cnt++;
      $display("unexpected timeout: expected end of tests, seen hang");
      complete_run();
   end
endmodule : tb_qbp_pin_mux
`default_nettype wire
